// ### design/sfvt_pkg.sv
package sfvt_pkg;

   // command codes of the management link
   localparam logic [7:0] CMD_FIRST_ALERT_STATUS    = 8'h7f;
   localparam logic [7:0] CMD_FIRST_ALERT_ALT       = 8'h7e;
   localparam logic [7:0] CMD_VENDOR_FAULT_STATUS   = 8'h80;
   localparam logic [7:0] CMD_INPUT_VOLTAGE_READING = 8'h88;

   // first_alert_status layout
   localparam int          FIRST_ALERT_BIT   = 0;
   localparam logic [7:0]  FIRST_ALERT_RESET = 8'h00;

   // vendor_fault_status layout
   localparam int          VND_DISCONT_BIT   = 7;
   localparam int          VND_CTRL_OT_BIT   = 6;
   localparam int          VND_STAGE_FLT_BIT = 5;
   localparam int          VND_LINK_ERR_BIT  = 4;
   localparam int          VND_STAGE_OT_BIT  = 1;
   localparam int          VND_STAGE_UV_BIT  = 0;
   localparam logic [7:0]  VND_LATCHED_MASK  = 8'h73;
   localparam logic [7:0]  VND_RESET         = 8'h00;

   // input voltage reading, LINEAR11
   localparam int          VIN_MANT_W        = 11;
   localparam logic [4:0]  VIN_EXPONENT      = 5'h1b;
   localparam logic [10:0] VIN_MANT_MIN      = 11'h080;
   localparam logic [10:0] VIN_MANT_MAX      = 11'h280;
   localparam logic [15:0] VIN_RESET         = {VIN_EXPONENT, VIN_MANT_MIN};

   // timing
   localparam int          CLK_PERIOD_NS     = 20;
   localparam int          VIN_REFRESH_NS    = 190000;
   localparam int          VIN_REFRESH_CYC   = VIN_REFRESH_NS / CLK_PERIOD_NS;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [7:0]  code;
      logic [7:0]  data;
   } sfvt_cmd_t;

   typedef struct packed {
      logic        valid;
      logic        refused;
      logic [15:0] data;
   } sfvt_rsp_t;

   typedef struct packed {
      logic discontinuousModeLive;
      logic controllerThermalShutdown;
      logic driverSupplyLow;
      logic stageOverTemp;
      logic powerInputRailLow;
      logic stageLinkError;
      logic stageUndervoltage;
   } sfvt_fault_t;

endpackage

// ### design/sfvt_status_flags.sv
`timescale 1ns/1ps
module sfvt_status_flags #(
   parameter int         REFRESH_CYCLES = sfvt_pkg::VIN_REFRESH_CYC,
   parameter logic [7:0] FIRST_ALERT_CODE = sfvt_pkg::CMD_FIRST_ALERT_STATUS
) (
   input  wire logic                               clk_sys,
   input  wire logic                               sys_rst,
   input  wire sfvt_pkg::sfvt_cmd_t                cmd,
   input  wire logic                               clearFaults,
   input  wire logic                               outputTurnOn,
   input  wire logic                               alertDriveReq,
   input  wire logic                               alertLineLevel,
   input  wire sfvt_pkg::sfvt_fault_t              faultPins,
   input  wire logic [7:0]                         vendorDisable,
   input  wire logic [sfvt_pkg::VIN_MANT_W-1:0]    vinSense,
   output sfvt_pkg::sfvt_rsp_t                     rsp_q,
   output logic                                    otherSummaryBit_q,
   output logic                                    vendorSummaryBit_q,
   output logic [7:0]                              vendorFaultStatus_q,
   output logic [15:0]                             inputVoltageReading
);
   import sfvt_pkg::*;

   // only the two codes in circulation for this byte are accepted
   if (FIRST_ALERT_CODE != CMD_FIRST_ALERT_STATUS &&
       FIRST_ALERT_CODE != CMD_FIRST_ALERT_ALT) begin : g_bad_code
      $error("first-alert status code must be 7fh or 7eh");
   end

   function automatic logic isWrite(input sfvt_cmd_t c, input logic [7:0] code);
      isWrite = c.valid && c.write && (c.code == code);
   endfunction

   // pin synchronisers: first stage read by second stage only
   sfvt_fault_t faultMeta_q;
   sfvt_fault_t faultSync_q;
   logic        lineMeta_q;
   logic        lineSync_q;

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         faultMeta_q <= '0;
         faultSync_q <= '0;
         lineMeta_q  <= 1'b1;
         lineSync_q  <= 1'b1;
      end else begin
         faultMeta_q <= faultPins;
         faultSync_q <= faultMeta_q;
         lineMeta_q  <= alertLineLevel;
         lineSync_q  <= lineMeta_q;
      end
   end

   // first-alert flag
   logic       alertPrev_q;
   logic       alertPrev_d;
   logic       firstAlert_q;
   logic       firstAlert_d;
   logic       otherSummaryBit_d;
   logic       commonClear;
   logic       firstAlertSet;
   logic       firstAlertClear;

   always_comb begin
      commonClear = clearFaults | outputTurnOn;
      alertPrev_d = alertDriveReq;
      // line sampled high before our own drive starts: we were first
      firstAlertSet = alertDriveReq & ~alertPrev_q & lineSync_q;
      firstAlertClear = commonClear |
                        (isWrite(cmd, FIRST_ALERT_CODE) & cmd.data[FIRST_ALERT_BIT]);
      // set beats clear so a coincident event is not lost
      if (firstAlertSet) begin
         firstAlert_d = 1'b1;
      end else if (firstAlertClear) begin
         firstAlert_d = 1'b0;
      end else begin
         firstAlert_d = firstAlert_q;
      end
      otherSummaryBit_d = firstAlert_d;
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         alertPrev_q       <= 1'b0;
         firstAlert_q      <= FIRST_ALERT_RESET[FIRST_ALERT_BIT];
         otherSummaryBit_q <= 1'b0;
      end else begin
         alertPrev_q       <= alertPrev_d;
         firstAlert_q      <= firstAlert_d;
         otherSummaryBit_q <= otherSummaryBit_d;
      end
   end
   // the flag has no path to the alert drive; it only reports

   // vendor status
   logic [7:0] vendorSet;
   logic [7:0] vendorClr;
   logic [7:0] vendorFaultStatus_d;
   logic       vendorSummaryBit_d;

   always_comb begin
      vendorSet = '0;
      vendorSet[VND_CTRL_OT_BIT]   = faultSync_q.controllerThermalShutdown;
      vendorSet[VND_STAGE_FLT_BIT] = faultSync_q.driverSupplyLow |
                                     faultSync_q.stageOverTemp |
                                     faultSync_q.powerInputRailLow;
      vendorSet[VND_LINK_ERR_BIT]  = faultSync_q.stageLinkError;
      vendorSet[VND_STAGE_OT_BIT]  = faultSync_q.stageOverTemp;
      vendorSet[VND_STAGE_UV_BIT]  = faultSync_q.stageUndervoltage;
      // disabled faults never reach the flags; alert mask is not consulted
      vendorSet = vendorSet & ~vendorDisable & VND_LATCHED_MASK;
      vendorClr = {8{commonClear}};
      if (isWrite(cmd, CMD_VENDOR_FAULT_STATUS)) begin
         vendorClr = vendorClr | cmd.data;
      end
      vendorClr = vendorClr & VND_LATCHED_MASK;
      vendorFaultStatus_d = (vendorSet |
                             (vendorFaultStatus_q & ~vendorClr)) & VND_LATCHED_MASK;
      // live bit follows the stage directly, never latched
      vendorFaultStatus_d[VND_DISCONT_BIT] = faultSync_q.discontinuousModeLive &
                                             ~vendorDisable[VND_DISCONT_BIT];
      // live bit kept out of the summary
      vendorSummaryBit_d = |(vendorFaultStatus_d & VND_LATCHED_MASK);
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         vendorFaultStatus_q <= VND_RESET;
         vendorSummaryBit_q  <= 1'b0;
      end else begin
         vendorFaultStatus_q <= vendorFaultStatus_d;
         vendorSummaryBit_q  <= vendorSummaryBit_d;
      end
   end

   // telemetry
   sfvt_vin_sampler #(
      .REFRESH_CYCLES (REFRESH_CYCLES)
   ) u_vin (
      .clk_sys      (clk_sys),
      .sys_rst      (sys_rst),
      .vinSense     (vinSense),
      .vinReading_q (inputVoltageReading)
   );

   // command answers
   sfvt_rsp_t rsp_d;

   always_comb begin
      rsp_d = '0;
      rsp_d.valid = cmd.valid;
      if (cmd.valid) begin
         if (cmd.code == FIRST_ALERT_CODE) begin
            rsp_d.data = {15'h0000, firstAlert_q};
         end else if (cmd.code == CMD_VENDOR_FAULT_STATUS) begin
            rsp_d.data = {8'h00, vendorFaultStatus_q};
         end else if (cmd.code == CMD_INPUT_VOLTAGE_READING && !cmd.write) begin
            rsp_d.data = inputVoltageReading;
         end else begin
            // writes to the reading and unknown codes are refused
            rsp_d.refused = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         rsp_q <= '0;
      end else begin
         rsp_q <= rsp_d;
      end
   end

endmodule

// ### design/sfvt_vin_sampler.sv
`timescale 1ns/1ps
module sfvt_vin_sampler #(
   parameter int REFRESH_CYCLES = sfvt_pkg::VIN_REFRESH_CYC
) (
   input  wire logic                               clk_sys,
   input  wire logic                               sys_rst,
   input  wire logic [sfvt_pkg::VIN_MANT_W-1:0]    vinSense,
   output logic      [15:0]                        vinReading_q
);
   import sfvt_pkg::*;

   localparam int CW = $clog2(REFRESH_CYCLES + 1);

   // a zero period would leave the divider without a terminal count
   if (REFRESH_CYCLES < 1) begin : g_bad_refresh
      $error("refresh period must be at least one cycle");
   end

   logic [CW-1:0] divCount_q;
   logic [CW-1:0] divCount_d;
   logic          refreshEn;
   logic [15:0]   vinReading_d;
   logic [10:0]   clamped;

   // refresh strobe from a divider, one cycle wide
   always_comb begin
      refreshEn = (divCount_q == CW'(REFRESH_CYCLES - 1));
      divCount_d = refreshEn ? '0 : divCount_q + CW'(1);
   end

   always_comb begin
      if (vinSense < VIN_MANT_MIN) begin
         clamped = VIN_MANT_MIN;
      end else if (vinSense > VIN_MANT_MAX) begin
         clamped = VIN_MANT_MAX;
      end else begin
         clamped = vinSense;
      end
      vinReading_d = refreshEn ? {VIN_EXPONENT, clamped} : vinReading_q;
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         divCount_q   <= '0;
         vinReading_q <= VIN_RESET;
      end else begin
         divCount_q   <= divCount_d;
         vinReading_q <= vinReading_d;
      end
   end

endmodule

// ### verification/sfvt_alert_host_model.sv
`timescale 1ns/1ps
// shared alert wire: pull-up holds it high unless the device itself or another device pulls low
module sfvt_alert_host_model (
   input  wire logic clk_sys,
   input  wire logic otherPullLow,
   input  wire logic ownDrive,
   output logic      alertLineLevel
);
   // wired low by anyone; the device's own drive shows a cycle later
   always_ff @(posedge clk_sys) alertLineLevel <= !(otherPullLow | ownDrive);
endmodule

// ### verification/sfvt_status_flags_properties.sv
`timescale 1ns/1ps
module sfvt_status_flags_properties
   import sfvt_pkg::*;
(
   input wire logic                clk_sys,
   input wire logic                sys_rst,
   input wire sfvt_pkg::sfvt_cmd_t cmd,
   input wire logic                clearFaults,
   input wire logic                alertDriveReq,
   input wire sfvt_pkg::sfvt_fault_t faultPins,
   input wire logic [7:0]          vendorDisable,
   input wire sfvt_pkg::sfvt_rsp_t rsp_q,
   input wire logic                otherSummaryBit_q,
   input wire logic                vendorSummaryBit_q,
   input wire logic [7:0]          vendorFaultStatus_q,
   input wire logic [15:0]         inputVoltageReading
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   // pins must stay quiet long enough to flush the synchronisers
   sequence pinsQuiet;
      (faultPins == '0) [*3];
   endsequence
   sequence otHeld;
      (faultPins.stageOverTemp && vendorDisable == 8'h00) [*3];
   endsequence
   a_cmd_answer: assert property (cmd.valid |=> rsp_q.valid)
      else $error("request not answered");
   a_no_spurious: assert property (!cmd.valid |=> rsp_q == '0)
      else $error("response without request");
   a_vin_ro: assert property (cmd.valid && cmd.write &&
      cmd.code == CMD_INPUT_VOLTAGE_READING |=> rsp_q.refused && rsp_q.data == 16'h0000)
      else $error("voltage write not refused");
   a_byte_upper: assert property (cmd.valid && cmd.code == CMD_VENDOR_FAULT_STATUS
      |=> !rsp_q.refused && rsp_q.data[15:8] == 8'h00) else $error("vendor byte answer bad");
   a_reserved_zero: assert property (vendorFaultStatus_q[3:2] == 2'b00)
      else $error("reserved vendor bits set");
   a_summary_or: assert property (vendorSummaryBit_q ==
      |(vendorFaultStatus_q & VND_LATCHED_MASK)) else $error("vendor summary wrong");
   a_vin_clamp: assert property (inputVoltageReading[15:11] == VIN_EXPONENT &&
      inputVoltageReading[10:0] >= VIN_MANT_MIN && inputVoltageReading[10:0] <= VIN_MANT_MAX)
      else $error("voltage reading out of range");
   a_alert_cause: assert property ($rose(otherSummaryBit_q) |-> $past(alertDriveReq))
      else $error("first alert without own alert");
   a_clear_all: assert property (pinsQuiet ##0 clearFaults |=>
      (vendorFaultStatus_q & VND_LATCHED_MASK) == 8'h00) else $error("clear missed");
   a_stage_ot: assert property (otHeld |-> ##[1:2]
      (vendorFaultStatus_q[1] && vendorFaultStatus_q[5])) else $error("stage ot not latched");
endmodule
bind sfvt_status_flags sfvt_status_flags_properties chk_u (.clk_sys, .sys_rst, .cmd,
   .clearFaults, .alertDriveReq, .faultPins, .vendorDisable, .rsp_q, .otherSummaryBit_q,
   .vendorSummaryBit_q, .vendorFaultStatus_q, .inputVoltageReading);

// ### verification/status_flags_vin_telemetry_tb.sv
`timescale 1ns/1ps
module status_flags_vin_telemetry_tb;
   import sfvt_pkg::*;
   localparam int RC = 8;
   logic        clk_sys = 1'b0;
   logic        sys_rst = 1'b1;
   sfvt_cmd_t   cmd = '0;
   logic        clearFaults = 1'b0;
   logic        outputTurnOn = 1'b0;
   logic        alertDriveReq = 1'b0;
   logic        pullLow = 1'b0;
   sfvt_fault_t faultPins = '0;
   logic [7:0]  vendorDisable = 8'h00;
   logic [10:0] vinSense = 11'h000;
   sfvt_rsp_t   rsp_q, r;
   logic        otherSummaryBit_q, vendorSummaryBit_q, alertLineLevel;
   logic [7:0]  vendorFaultStatus_q;
   logic [15:0] inputVoltageReading;
   logic [10:0] vins [3] = '{11'h000, 11'h7ff, 11'h12c};
   logic [15:0] vexp [3] = '{16'hd880, 16'hda80, 16'hd92c};
   int          num_errors = 0;
   int          cmp_count = 0;
   always #10 clk_sys = !clk_sys;
   sfvt_alert_host_model host_u (.clk_sys, .otherPullLow(pullLow), .ownDrive(alertDriveReq),
      .alertLineLevel);
   sfvt_status_flags #(.REFRESH_CYCLES(RC)) dut_u (.clk_sys, .sys_rst, .cmd, .clearFaults,
      .outputTurnOn, .alertDriveReq, .alertLineLevel, .faultPins, .vendorDisable, .vinSense,
      .rsp_q, .otherSummaryBit_q, .vendorSummaryBit_q, .vendorFaultStatus_q,
      .inputVoltageReading);
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   // called on a rising edge; answer read mid-cycle while it stands
   task automatic access(input logic w, input logic [7:0] c, input logic [7:0] d);
      cmd <= '{1'b1, w, c, d};
      @(posedge clk_sys);
      cmd <= '0;
      @(negedge clk_sys);
      r = rsp_q;
      @(posedge clk_sys);
   endtask
   task automatic rd(input logic [7:0] c, input logic [15:0] exp);
      access(1'b0, c, 8'h00);
      check(r.data, exp);
   endtask
   task automatic summarize;
      $display("compares %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      tick(3);
      sys_rst <= 1'b0;
      rd(CMD_FIRST_ALERT_STATUS, 16'h0000);
      rd(CMD_VENDOR_FAULT_STATUS, 16'h0000);
      rd(CMD_INPUT_VOLTAGE_READING, 16'hd880);
      access(1'b0, 8'h81, 8'h00);
      check({15'h0, r.refused}, 16'h0001);
      $display("test reset done");
      faultPins <= sfvt_fault_t'(7'h6b);
      tick(5);
      faultPins <= sfvt_fault_t'(7'h40);
      tick(4);
      rd(CMD_VENDOR_FAULT_STATUS, 16'h00f3);
      @(negedge clk_sys);
      check({15'h0, vendorSummaryBit_q}, 16'h0001);
      check({8'h00, vendorFaultStatus_q}, 16'h00f3);
      @(posedge clk_sys);
      access(1'b1, CMD_VENDOR_FAULT_STATUS, 8'h00);
      access(1'b1, CMD_VENDOR_FAULT_STATUS, 8'h8c);
      rd(CMD_VENDOR_FAULT_STATUS, 16'h00f3);
      access(1'b1, CMD_VENDOR_FAULT_STATUS, 8'h20);
      rd(CMD_VENDOR_FAULT_STATUS, 16'h00d3);
      faultPins <= '0;
      tick(4);
      rd(CMD_VENDOR_FAULT_STATUS, 16'h0053);
      clearFaults <= 1'b1;
      tick(1);
      clearFaults <= 1'b0;
      rd(CMD_VENDOR_FAULT_STATUS, 16'h0000);
      $display("test vendor flags done");
      for (int i = 0; i < 2; i++) begin
         faultPins <= sfvt_fault_t'(i == 0 ? 7'h10 : 7'h04);
         tick(5);
         faultPins <= '0;
         tick(3);
         rd(CMD_VENDOR_FAULT_STATUS, 16'h0020);
         outputTurnOn <= 1'b1;
         tick(1);
         outputTurnOn <= 1'b0;
         rd(CMD_VENDOR_FAULT_STATUS, 16'h0000);
      end
      vendorDisable <= 8'hc0;
      faultPins <= sfvt_fault_t'(7'h60);
      tick(5);
      rd(CMD_VENDOR_FAULT_STATUS, 16'h0000);
      faultPins <= '0;
      // disable held until the synchronisers have flushed the fault
      tick(3);
      vendorDisable <= 8'h00;
      $display("test stage faults done");
      tick(3);
      alertDriveReq <= 1'b1;
      tick(2);
      @(negedge clk_sys);
      check({15'h0, otherSummaryBit_q}, 16'h0001);
      @(posedge clk_sys);
      rd(CMD_FIRST_ALERT_STATUS, 16'h0001);
      access(1'b1, CMD_FIRST_ALERT_STATUS, 8'hff);
      rd(CMD_FIRST_ALERT_STATUS, 16'h0000);
      @(negedge clk_sys);
      check({15'h0, otherSummaryBit_q}, 16'h0000);
      @(posedge clk_sys);
      alertDriveReq <= 1'b0;
      pullLow <= 1'b1;
      tick(5);
      alertDriveReq <= 1'b1;
      tick(3);
      rd(CMD_FIRST_ALERT_STATUS, 16'h0000);
      alertDriveReq <= 1'b0;
      pullLow <= 1'b0;
      $display("test first alert done");
      for (int i = 0; i < 3; i++) begin
         vinSense <= vins[i];
         tick(2 * RC + 4);
         rd(CMD_INPUT_VOLTAGE_READING, vexp[i]);
      end
      access(1'b1, CMD_INPUT_VOLTAGE_READING, 8'hff);
      check({15'h0, r.refused}, 16'h0001);
      $display("test voltage reading done");
      summarize();
   end
   // whole run needs under two hundred cycles
   initial begin
      tick(3000);
      num_errors++;
      summarize();
   end
endmodule
